// [hdl/rsc_setup_regs.vh]
// constants for the readout setup controller
`ifndef RSC_SETUP_REGS_VH
`define RSC_SETUP_REGS_VH
// key codes (one-hot pulse vector index)
`define RSC_KEY_X          0
`define RSC_KEY_Y          1
`define RSC_KEY_Z          2
`define RSC_KEY_NEXT       3
`define RSC_KEY_UNIT       4
`define RSC_KEY_ABSINC     5
`define RSC_KEY_OTHER      6
`define RSC_KEY_W          7
// resolution codes: 0 = 10.0um ... 6 = 0.1um
`define RSC_RES_STEPS      3'h7
`define RSC_RES_LAST       3'h6
`define RSC_RES_RST        3'h0
// resolution weights in 0.1 micron units
`define RSC_W0             8'h64
`define RSC_W1             8'h32
`define RSC_W2             8'h14
`define RSC_W3             8'h0a
`define RSC_W4             8'h05
`define RSC_W5             8'h02
`define RSC_W6             8'h01
// reset/clear defaults
`define RSC_DIR_NEG_RST    3'h7
`define RSC_DIA_RST        3'h0
`define RSC_WARN_EN_RST    1'b0
`define RSC_UNIT_INCH_RST  1'b1
// 0.2000 inch = 50800 units of 0.1 micron
`define RSC_WIN_RST        32'h0000c670
// screen codes
`define RSC_SCR_RES        3'h0
`define RSC_SCR_DIR        3'h1
`define RSC_SCR_DIA        3'h2
`define RSC_SCR_WIN        3'h3
`define RSC_SCR_WEN        3'h4
`define RSC_SCR_LAST       3'h4
`endif

// [hdl/rsc_axis.v]
// one axis counter with direction, diameter and near-zero window
`timescale 1ns/1ps
`default_nettype none
`include "rsc_setup_regs.vh"
module rsc_axis #(
  parameter W = 32
) (
  input  wire         clk_sys_in,
  input  wire         rst_b_in,
  input  wire         step_in,
  input  wire         up_in,
  input  wire         clear_in,
  input  wire [2:0]   res_in,
  input  wire         reverse_count_sense_in,
  input  wire         dia_in,
  input  wire         warn_en_in,
  input  wire [W-1:0] win_in,
  output reg  [W-1:0] pos_out,
  output reg          near_pos_out,
  output reg          near_neg_out
);
  reg  [7:0]   weight;
  wire [W-1:0] wext;
  wire [W-1:0] delta;
  wire         cnt_up;
  wire [W-1:0] next_pos;
  wire [W-1:0] mag;
  always @* begin
    case (res_in)
      3'h0: weight = `RSC_W0;
      3'h1: weight = `RSC_W1;
      3'h2: weight = `RSC_W2;
      3'h3: weight = `RSC_W3;
      3'h4: weight = `RSC_W4;
      3'h5: weight = `RSC_W5;
      default: weight = `RSC_W6;
    endcase
  end
  assign wext = {{(W-8){1'b0}}, weight};
  assign delta = dia_in ? {wext[W-2:0], 1'b0} : wext;
  assign cnt_up = up_in ^ reverse_count_sense_in;
  assign next_pos = cnt_up ? pos_out + delta : pos_out - delta;
  assign mag = next_pos[W-1] ? (~next_pos + 1'b1) : next_pos;
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pos_out      <= {W{1'b0}};
      near_pos_out <= 1'b0;
      near_neg_out <= 1'b0;
    end else if (clear_in) begin
      pos_out      <= {W{1'b0}};
      near_pos_out <= 1'b0;
      near_neg_out <= 1'b0;
    end else if (step_in) begin
      pos_out <= next_pos;
      near_pos_out <= warn_en_in && (mag <= win_in) && !next_pos[W-1];
      near_neg_out <= warn_en_in && (mag <= win_in) && next_pos[W-1];
    end
  end
endmodule // rsc_axis
`default_nettype wire

// [hdl/rsc_setup_ctrl.v]
// setup screen controller and three axis counters
`timescale 1ns/1ps
`default_nettype none
`include "rsc_setup_regs.vh"
module rsc_setup_ctrl #(
  parameter W = 32
) (
  input  wire         clk_sys_in,
  input  wire         rst_b_in,
  input  wire [7:0]   key_in,
  input  wire         power_up_flash_in,
  input  wire         mem_clear_in,
  input  wire [2:0]   scale_step_in,
  input  wire [2:0]   scale_up_in,
  input  wire [W-1:0] win_data_in,
  input  wire         nv_valid_in,
  input  wire [2:0]   nv_dir_in,
  input  wire [2:0]   nv_dia_in,
  input  wire [8:0]   nv_res_in,
  input  wire         nv_warn_en_in,
  input  wire         nv_unit_inch_in,
  input  wire [W-1:0] nv_win_in,
  output reg  [2:0]   mode_out,
  output reg  [2:0]   screen_out,
  output reg          unit_inch_out,
  output reg  [8:0]   res_out,
  output reg  [2:0]   reverse_count_sense_out,
  output reg  [2:0]   dia_out,
  output reg          warn_en_out,
  output reg  [W-1:0] win_out,
  output reg          nv_write_out,
  output wire [3*W-1:0] pos_out,
  output wire [2:0]   near_pos_out,
  output wire [2:0]   near_neg_out
);
  // ****************************************************************
  // modes
  // ****************************************************************
  localparam [2:0] M_FLASH = 3'b001;
  localparam [2:0] M_SETUP = 3'b010;
  localparam [2:0] M_NORM  = 3'b100;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [7:0] key_s1;
  reg [7:0] key_s2;
  reg [7:0] key_s3;
  reg [4:0] ctl_s1;
  reg [4:0] ctl_s2;
  reg [2:0] up_s1;
  reg [2:0] up_s2;
  reg [2:0] stp_s1;
  reg [2:0] stp_s2;
  reg [2:0] stp_s3;
  reg       nv_loaded;
  wire [7:0] kp;
  wire [2:0] sp;
  wire       flash;
  wire       mclr;
  wire       nvv;

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_s1 <= 8'h00;
      key_s2 <= 8'h00;
      key_s3 <= 8'h00;
      // flash assumed on until the synchroniser has filled
      ctl_s1 <= 5'h01;
      ctl_s2 <= 5'h01;
      up_s1  <= 3'h0;
      up_s2  <= 3'h0;
      stp_s1 <= 3'h0;
      stp_s2 <= 3'h0;
      stp_s3 <= 3'h0;
    end else begin
      key_s1 <= key_in;
      key_s2 <= key_s1;
      key_s3 <= key_s2;
      ctl_s1 <= {2'b00, nv_valid_in, mem_clear_in, power_up_flash_in};
      ctl_s2 <= ctl_s1;
      up_s1  <= scale_up_in;
      up_s2  <= up_s1;
      stp_s1 <= scale_step_in;
      stp_s2 <= stp_s1;
      stp_s3 <= stp_s2;
    end
  end
  assign kp    = key_s2 & ~key_s3;
  assign sp    = stp_s2 & ~stp_s3;
  assign flash = ctl_s2[0];
  assign mclr  = ctl_s2[1];
  assign nvv   = ctl_s2[2];

  // ****************************************************************
  // mode and screen sequencing
  // ****************************************************************
  wire in_setup;
  wire axis_key;
  wire setup_key;
  assign in_setup  = (mode_out == M_SETUP);
  assign axis_key  = |kp[`RSC_KEY_Z:`RSC_KEY_X];
  assign setup_key = axis_key | kp[`RSC_KEY_NEXT] | kp[`RSC_KEY_UNIT];

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_out   <= M_FLASH;
      screen_out <= `RSC_SCR_RES;
    end else begin
      case (mode_out)
        M_FLASH: begin
          if (mclr) begin
            mode_out   <= M_SETUP;
            screen_out <= `RSC_SCR_RES;
          end else if (flash && key_s2[`RSC_KEY_ABSINC]) begin
            mode_out   <= M_SETUP;
            screen_out <= `RSC_SCR_RES;
          end else if (flash && (|kp)) begin
            mode_out <= M_NORM;
          end else if (!flash) begin
            mode_out <= M_NORM;
          end
        end
        M_SETUP: begin
          if (kp[`RSC_KEY_NEXT]) begin
            if (screen_out == `RSC_SCR_LAST)
              screen_out <= `RSC_SCR_RES;
            else
              screen_out <= screen_out + 3'h1;
          end else if ((|kp) && !setup_key) begin
            mode_out <= M_NORM;
          end
        end
        M_NORM: begin
          mode_out <= M_NORM;
        end
        default: begin
          mode_out <= M_FLASH;
        end
      endcase
    end
  end

  // ****************************************************************
  // settings
  // ****************************************************************
  integer i;
  reg [8:0] next_res;
  always @* begin
    next_res = res_out;
    for (i = 0; i < 3; i = i + 1) begin
      if (kp[i]) begin
        if (res_out[3*i +: 3] == `RSC_RES_LAST)
          next_res[3*i +: 3] = `RSC_RES_RST;
        else
          next_res[3*i +: 3] = res_out[3*i +: 3] + 3'h1;
      end
    end
  end

  wire change;
  assign change = in_setup && (|kp);

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      res_out                 <= {3{`RSC_RES_RST}};
      reverse_count_sense_out <= `RSC_DIR_NEG_RST;
      dia_out                 <= `RSC_DIA_RST;
      warn_en_out             <= `RSC_WARN_EN_RST;
      unit_inch_out           <= `RSC_UNIT_INCH_RST;
      win_out                 <= `RSC_WIN_RST;
      nv_write_out            <= 1'b0;
      nv_loaded               <= 1'b0;
    end else begin
      nv_write_out <= change;
      if (mclr && mode_out == M_FLASH) begin
        res_out                 <= {3{`RSC_RES_RST}};
        reverse_count_sense_out <= `RSC_DIR_NEG_RST;
        dia_out                 <= `RSC_DIA_RST;
        warn_en_out             <= `RSC_WARN_EN_RST;
        unit_inch_out           <= `RSC_UNIT_INCH_RST;
        win_out                 <= `RSC_WIN_RST;
        nv_write_out            <= 1'b1;
        nv_loaded               <= 1'b1;
      end else if (nvv && !nv_loaded) begin
        res_out                 <= nv_res_in;
        reverse_count_sense_out <= nv_dir_in;
        dia_out                 <= nv_dia_in;
        warn_en_out             <= nv_warn_en_in;
        unit_inch_out           <= nv_unit_inch_in;
        win_out                 <= nv_win_in;
        nv_loaded               <= 1'b1;
      end else if (in_setup) begin
        if (kp[`RSC_KEY_UNIT])
          unit_inch_out <= ~unit_inch_out;
        case (screen_out)
          `RSC_SCR_RES: res_out <= next_res;
          `RSC_SCR_DIR: reverse_count_sense_out <=
            reverse_count_sense_out ^ kp[2:0];
          `RSC_SCR_DIA: dia_out <= dia_out ^ kp[2:0];
          `RSC_SCR_WIN: if (axis_key) win_out <= win_data_in;
          `RSC_SCR_WEN: if (kp[`RSC_KEY_Z]) warn_en_out <= ~warn_en_out;
          default: res_out <= res_out;
        endcase
      end
    end
  end

  // ****************************************************************
  // axis counters
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      rsc_axis #(.W(W)) u_axis (
        .clk_sys_in             (clk_sys_in),
        .rst_b_in               (rst_b_in),
        .step_in                (sp[g]),
        .up_in                  (up_s2[g]),
        .clear_in               (mclr),
        .res_in                 (res_out[3*g +: 3]),
        .reverse_count_sense_in (reverse_count_sense_out[g]),
        .dia_in                 (dia_out[g]),
        .warn_en_in             (warn_en_out),
        .win_in                 (win_out),
        .pos_out                (pos_out[W*g +: W]),
        .near_pos_out           (near_pos_out[g]),
        .near_neg_out           (near_neg_out[g])
      );
    end
  endgenerate
endmodule // rsc_setup_ctrl
`default_nettype wire

// [tb/rsc_setup_ctrl_monitor.sv]
// port checker for the setup controller
`timescale 1ns/1ps
`default_nettype none
module rsc_setup_monitor #(
  parameter W = 32
) (
  input wire logic         clk_sys_in,
  input wire logic         rst_b_in,
  input wire logic [7:0]   key_in,
  input wire logic [2:0]   mode_out,
  input wire logic [2:0]   screen_out,
  input wire logic [8:0]   res_out,
  input wire logic [2:0]   dia_out,
  input wire logic         warn_en_out,
  input wire logic         nv_write_out,
  input wire logic [2:0]   near_pos_out,
  input wire logic [2:0]   near_neg_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  chk_mode_onehot: assert property (
    $onehot(mode_out)) else $error("mode not one-hot");
  chk_normal_stays: assert property (
    mode_out == 3'h4 |=> mode_out == 3'h4) else $error("left normal");
  chk_screen_range: assert property (
    screen_out <= 3'h4) else $error("screen out of range");
  chk_res_range: assert property (
    res_out[2:0] <= 3'h6 && res_out[5:3] <= 3'h6 && res_out[8:6] <= 3'h6)
    else $error("resolution code out of range");
  chk_nv_pulse: assert property (
    nv_write_out |=> !nv_write_out) else $error("store pulse too long");
  chk_next_answer: assert property (
    $rose(key_in[3]) && mode_out == 3'h2 |-> ##[1:3] nv_write_out)
    else $error("next press not stored");
  chk_near_sides: assert property (
    (near_pos_out & near_neg_out) == 3'h0) else $error("both near sides");
  chk_dia_screen: assert property (
    $changed(dia_out) && mode_out == 3'h2 |-> screen_out == 3'h2)
    else $error("diameter changed off its screen");
  chk_warn_screen: assert property (
    $changed(warn_en_out) && mode_out == 3'h2 |-> screen_out == 3'h4)
    else $error("warning enable changed off its screen");
endmodule // rsc_setup_monitor
`default_nettype wire

// [tb/rsc_far_model.sv]
// keypad and scale encoder model
`timescale 1ns/1ps
`default_nettype none
module rsc_far_model (
  input  wire logic       clk_sys_in,
  output logic      [7:0] key_out,
  output logic      [2:0] step_out,
  output logic      [2:0] up_out
);
  initial begin
    key_out = 8'h00;
    step_out = 3'h0;
    up_out = 3'h0;
  end
  task automatic hold(input int k, input logic v);
    #1 key_out[k] = v;
  endtask
  task automatic press(input int k);
    @(posedge clk_sys_in) #1 key_out[k] = 1'b1;
    repeat (4) @(posedge clk_sys_in);
    #1 key_out[k] = 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
  task automatic move(input int a, input logic u);
    @(posedge clk_sys_in) #1 up_out[a] = u;
    repeat (2) @(posedge clk_sys_in);
    #1 step_out[a] = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1 step_out[a] = 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask
endmodule // rsc_far_model
`default_nettype wire

// [tb/rsc_setup_ctrl_bench.sv]
// self-checking bench for the setup controller
`timescale 1ns/1ps
`default_nettype none
module rsc_setup_ctrl_bench;
  localparam int W = 32;
  logic           clk_sys_in = 1'b0;
  logic           rst_b_in = 1'b0;
  logic           pwr = 1'b1, clr = 1'b0, nv_ok = 1'b1, nv_inch, inch;
  logic           nv_wen, wen;
  logic [2:0]     nv_dir, nv_dia, rev, dia;
  logic [8:0]     nv_res, res;
  logic [W-1:0]   nv_win, wdat = '0, win;
  wire  [7:0]     keys;
  wire  [2:0]     step, up, mode, scr, rv, dg, np, nn;
  wire  [8:0]     res_o;
  wire            inch_o, wen_o, nvw;
  wire  [W-1:0]   win_o;
  wire  [3*W-1:0] pos;
  int             seed, cyc, err_total, tests_run, i, a, d, ex[3];
  int             wts[7] = '{100, 50, 20, 10, 5, 2, 1};
  logic           u;

  always #10 clk_sys_in = ~clk_sys_in;

  rsc_far_model i_far (.clk_sys_in(clk_sys_in), .key_out(keys),
    .step_out(step), .up_out(up));

  rsc_setup_ctrl #(.W(W)) i_dut (.clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in), .key_in(keys), .power_up_flash_in(pwr),
    .mem_clear_in(clr), .scale_step_in(step), .scale_up_in(up),
    .win_data_in(wdat), .nv_valid_in(nv_ok), .nv_dir_in(nv_dir),
    .nv_dia_in(nv_dia), .nv_res_in(nv_res), .nv_warn_en_in(nv_wen),
    .nv_unit_inch_in(nv_inch), .nv_win_in(nv_win), .mode_out(mode),
    .screen_out(scr), .unit_inch_out(inch_o), .res_out(res_o),
    .reverse_count_sense_out(rv), .dia_out(dg), .warn_en_out(wen_o),
    .win_out(win_o), .nv_write_out(nvw), .pos_out(pos),
    .near_pos_out(np), .near_neg_out(nn));

  task automatic chk(input string n, input logic [W-1:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    #1 rst_b_in = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1 rst_b_in = 1'b1;
    repeat (5) @(posedge clk_sys_in);
  endtask

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ************************************
  // main sequence
  // ************************************
  initial begin
    seed = 46;
    nv_dir = 3'($random(seed));
    nv_dia = 3'($random(seed));
    nv_inch = 1'($random(seed));
    nv_wen = 1'($random(seed));
    nv_win = W'($random(seed));
    for (i = 0; i < 3; i++) nv_res[3*i+:3] = 3'(($random(seed) & 255) % 7);
    do_reset();
    chk("res", nv_res, res_o);
    chk("dir", nv_dir, rv);
    chk("dia", nv_dia, dg);
    chk("inch", nv_inch, inch_o);
    chk("win", nv_win, win_o);
    chk("warn", nv_wen, wen_o);
    i_far.hold(5, 1'b1);
    repeat (5) @(posedge clk_sys_in);
    chk("mode", 3'h2, mode);
    i_far.hold(5, 1'b0);
    #1 pwr = 1'b0;
    {res, rev, dia, inch} = {nv_res, nv_dir, nv_dia, nv_inch};
    for (i = 0; i < 7; i++) begin
      i_far.press(0);
      res[2:0] = (res[2:0] == 3'h6) ? 3'h0 : res[2:0] + 3'h1;
      chk("res", res, res_o);
    end
    for (i = 0; i < 2; i++) begin
      i_far.press(4);
      inch = ~inch;
      chk("inch", inch, inch_o);
    end
    i_far.press(3);
    chk("screen", 3'h1, scr);
    i_far.press(1);
    rev[1] = ~rev[1];
    chk("dir", rev, rv);
    i_far.press(3);
    i_far.press(2);
    dia[2] = ~dia[2];
    chk("dia", dia, dg);
    i_far.press(3);
    wdat = W'(($random(seed) & 255) + 100);
    win = wdat;
    i_far.press(0);
    chk("win", win, win_o);
    i_far.press(3);
    i_far.press(2);
    wen = ~nv_wen;
    chk("warn", wen, wen_o);
    i_far.press(6);
    chk("mode", 3'h4, mode);
    i_far.press(3);
    chk("screen", 3'h4, scr);
    for (i = 0; i < 24; i++) begin
      a = ($random(seed) & 255) % 3;
      u = 1'($random(seed));
      i_far.move(a, u);
      d = wts[res[3*a+:3]] * (dia[a] ? 2 : 1);
      ex[a] += (u ^ rev[a]) ? d : -d;
      chk("pos", ex[a], pos[W*a+:W]);
      chk("near_pos", wen && ex[a] >= 0 && ex[a] <= int'(win), np[a]);
      chk("near_neg", wen && ex[a] < 0 && -ex[a] <= int'(win), nn[a]);
    end
    #1 nv_ok = 1'b0;
    pwr = 1'b1;
    do_reset();
    i_far.press(7);
    chk("mode", 3'h4, mode);
    do_reset();
    #1 clr = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    chk("mode", 3'h2, mode);
    chk("res", 9'h000, res_o);
    chk("dir", 3'h7, rv);
    chk("dia", 3'h0, dg);
    chk("win", 32'h0000c670, win_o);
    chk("pos", '0, pos[W-1:0]);
    tally_and_finish();
  end
endmodule // rsc_setup_ctrl_bench

bind rsc_setup_ctrl rsc_setup_monitor #(.W(W)) i_mon (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .key_in(key_in),
  .mode_out(mode_out), .screen_out(screen_out), .res_out(res_out),
  .dia_out(dia_out), .warn_en_out(warn_en_out),
  .nv_write_out(nv_write_out), .near_pos_out(near_pos_out),
  .near_neg_out(near_neg_out));
`default_nettype wire
